// ==== hdl/cmp_mismatch.sv ====
// Latch of both comparator outputs and the mismatch detector.
// Assumes live inputs are already synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cmp_mismatch (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic [1:0] live, // Synchronised outputs, second then first.
	input wire logic access, // Control register access this cycle.
	output logic mismatch // Live outputs differ from the latch.
);
	logic [1:0] seen_reg; // Values captured at the last access.
	logic [1:0] seen_next; // Next captured values.
	// Captures the live outputs on every control register access.
	always_comb begin
		seen_next = access ? live : seen_reg;
	end
	// Registers the captured values.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_reg <= 2'h0;
		end else begin
			seen_reg <= seen_next;
		end
	end
	// A mismatch is held off in the access cycle itself.
	assign mismatch = (live != seen_reg) && !access;
endmodule
`default_nettype wire

// ==== hdl/cmp_sync.sv ====
// Two-stage level synchroniser for one comparator output.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cmp_sync #(
	parameter int STAGES = 2
) (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic d, // Raw level.
	output logic q // Synchronised level.
);
	logic [STAGES-1:0] sh_reg; // Shift chain.
	logic [STAGES-1:0] sh_next; // Next value of the chain.
	// Refuses a chain too short to settle a raw level.
	if (STAGES < 2) begin : g_bad_stages
		$error("cmp_sync needs at least two stages.");
	end
	// Shifts the level in one stage per clock.
	always_comb begin
		sh_next = {sh_reg[STAGES-2:0], d};
	end
	// Registers the chain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg <= '0;
		end else begin
			sh_reg <= sh_next;
		end
	end
	assign q = sh_reg[STAGES-1];
endmodule
`default_nettype wire

// ==== hdl/cmp_top.sv ====
// Digital side of a dual comparator with change interrupt, reached over APB.
// Assumes the analog comparators deliver raw levels and follow the route outputs.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_cfg.svh"
module cmp_top #(
	parameter int SYNC_STAGES = `SYNC_STAGES
) (
	input wire logic pclk, // Clock, 100 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data, registered.
	output logic pready, // APB ready, registered.
	output logic pslverr, // APB error, registered.
	input wire logic cmp1_raw, // First comparator raw level (positive above negative).
	input wire logic cmp2_raw, // Second comparator raw level.
	input wire logic sleeping, // Core is in sleep.
	output cmp_pkg::route_s route, // Analog routing, registered.
	output logic [2:0] comparator_mode_field, // Mode field, registered.
	output logic cis_sel, // Input switch bit, registered.
	output logic cmp_irq, // Core comparator interrupt request, registered.
	output logic wake_req, // Wake request to the core, registered.
	output logic irq // Block interrupt line, registered.
);
	import cmp_pkg::*;
	// Refuses a synchroniser too short to settle a raw comparator level.
	if (SYNC_STAGES < 2) begin : g_bad_stages
		$error("cmp_top needs two synchroniser stages.");
	end
	logic first_compare_output; // Synchronised first output.
	logic second_compare_output; // Synchronised second output.
	logic mismatch; // Outputs differ from the latch.
	logic setup; // APB setup phase seen.
	logic ctrl_access; // Control register read or write this cycle.
	logic [3:0] mode_reg, mode_next; // Mode field and input switch.
	logic compare_change_flag_reg, compare_change_flag_next; // Change flag.
	logic compare_change_irq_enable_reg, compare_change_irq_enable_next; // Local enable.
	logic peripheral_irq_enable_reg, peripheral_irq_enable_next; // Peripheral enable.
	logic global_irq_enable_reg, global_irq_enable_next; // Global enable.
	evt_s stat_reg, stat_next; // Sticky event bits.
	evt_s en_reg, en_next; // Event enables.
	acc_e acc_reg, acc_next; // Bus access state.
	logic [31:0] rdata_reg, rdata_next; // Read data.
	logic err_reg, err_next; // Error answer.
	logic cmp_irq_reg, cmp_irq_next; // Core request.
	logic wake_reg, wake_next; // Wake request.
	logic irq_reg, irq_next; // Block interrupt.
	logic mask_off; // Comparators powered down.
	logic live1, live2; // Outputs gated by power.
	route_s route_reg; // Registered analog routing.
	route_s route_next; // Routing that follows the next mode.
	// Synchronises the two comparator levels.
	cmp_sync #(.STAGES(SYNC_STAGES)) u_sync1 (
		.pclk(pclk),
		.presetn(presetn),
		.d(cmp1_raw),
		.q(first_compare_output)
	);
	cmp_sync #(.STAGES(SYNC_STAGES)) u_sync2 (
		.pclk(pclk),
		.presetn(presetn),
		.d(cmp2_raw),
		.q(second_compare_output)
	);
	// Powered-down modes force the outputs low.
	assign mask_off = (mode_reg[2:0] == `MODE_RESET) || (mode_reg[2:0] == `MODE_OFF);
	assign live1 = first_compare_output && !mask_off;
	assign live2 = second_compare_output && !mask_off;
	assign setup = psel && !penable;
	assign ctrl_access = setup && (paddr == `OFF_CTRL);
	// Watches the outputs against the value seen at the last access.
	cmp_mismatch u_mm (
		.pclk(pclk),
		.presetn(presetn),
		.live({live2, live1}),
		.access(ctrl_access),
		.mismatch(mismatch)
	);
	// Computes the register file, flags and bus answer.
	always_comb begin
		mode_next = mode_reg;
		compare_change_flag_next = compare_change_flag_reg;
		compare_change_irq_enable_next = compare_change_irq_enable_reg;
		peripheral_irq_enable_next = peripheral_irq_enable_reg;
		global_irq_enable_next = global_irq_enable_reg;
		stat_next = stat_reg;
		en_next = en_reg;
		rdata_next = rdata_reg;
		err_next = 1'b0;
		acc_next = ACC_IDLE;
		if (setup) begin
			// Setup cycle: answer one cycle later.
			acc_next = ACC_DONE;
			rdata_next = 32'h0;
			if (pwrite) begin
				case (paddr)
					`OFF_CTRL: begin
						mode_next = pwdata[3:0];
					end
					`OFF_FLAG: begin
						compare_change_flag_next = pwdata[`BIT_CHG];
					end
					`OFF_PEN: begin
						// Local enable of the change interrupt.
						compare_change_irq_enable_next = pwdata[`BIT_LOCAL_EN];
					end
					`OFF_IRQC: begin
						// Peripheral and global enables share one word.
						peripheral_irq_enable_next = pwdata[`BIT_PERIPH_EN];
						global_irq_enable_next = pwdata[`BIT_GLOBAL_EN];
					end
					`OFF_IRQ_CLR: begin
						stat_next = stat_reg & ~evt_s'(pwdata[1:0]);
					end
					`OFF_IRQ_EN: begin
						en_next = evt_s'(pwdata[1:0]);
					end
					`OFF_IRQ_STAT: begin
						err_next = 1'b0;
					end
					default: begin
						err_next = 1'b1;
					end
				endcase
			end else begin
				case (paddr)
					`OFF_CTRL: begin
						rdata_next[`BIT_C2] = live2;
						rdata_next[`BIT_C1] = live1;
						rdata_next[3:0] = mode_reg;
					end
					`OFF_FLAG: begin
						rdata_next[`BIT_CHG] = compare_change_flag_reg;
					end
					`OFF_PEN: begin
						// Local enable reads back in place.
						rdata_next[`BIT_LOCAL_EN] = compare_change_irq_enable_reg;
					end
					`OFF_IRQC: begin
						// Both upper enables read back in place.
						rdata_next[`BIT_PERIPH_EN] = peripheral_irq_enable_reg;
						rdata_next[`BIT_GLOBAL_EN] = global_irq_enable_reg;
					end
					`OFF_IRQ_STAT: begin
						rdata_next[1:0] = stat_reg;
					end
					`OFF_IRQ_EN: begin
						rdata_next[1:0] = en_reg;
					end
					`OFF_IRQ_CLR: begin
						rdata_next = 32'h0;
					end
					default: begin
						err_next = 1'b1;
					end
				endcase
			end
		end
		// A mismatch sets the flag regardless of enables, and beats a clear.
		if (mismatch) begin
			compare_change_flag_next = 1'b1;
			stat_next.change = 1'b1;
		end
		// The core request needs every enable.
		cmp_irq_next = compare_change_flag_next && compare_change_irq_enable_next
			&& peripheral_irq_enable_next && global_irq_enable_next;
		// Waking from sleep needs only the local and peripheral enables.
		wake_next = sleeping && compare_change_flag_next
			&& compare_change_irq_enable_next && peripheral_irq_enable_next;
		if (wake_next) begin
			stat_next.wake = 1'b1;
		end
		irq_next = |(stat_next & en_next);
	end
	// Registers everything computed above.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= 4'(`CTRL_RESET);
			compare_change_flag_reg <= 1'b0;
			compare_change_irq_enable_reg <= 1'b0;
			peripheral_irq_enable_reg <= 1'b0;
			global_irq_enable_reg <= 1'b0;
			stat_reg <= '0;
			en_reg <= '0;
			acc_reg <= ACC_IDLE;
			rdata_reg <= 32'h0;
			err_reg <= 1'b0;
			cmp_irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			compare_change_flag_reg <= compare_change_flag_next;
			compare_change_irq_enable_reg <= compare_change_irq_enable_next;
			peripheral_irq_enable_reg <= peripheral_irq_enable_next;
			global_irq_enable_reg <= global_irq_enable_next;
			stat_reg <= stat_next;
			en_reg <= en_next;
			acc_reg <= acc_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
			cmp_irq_reg <= cmp_irq_next;
			wake_reg <= wake_next;
			irq_reg <= irq_next;
		end
	end
	// Analog routing: mode 010 ties the reference to both positive inputs;
	// other modes leave the pins free, shared or separate as wired.
	// It is worked out from the next mode, so the register follows the mode exactly.
	always_comb begin
		route_next.ref_to_pos1 = (mode_next[2:0] == `MODE_INTREF);
		route_next.ref_to_pos2 = (mode_next[2:0] == `MODE_INTREF);
		route_next.powered = (mode_next[2:0] != `MODE_RESET)
			&& (mode_next[2:0] != `MODE_OFF);
	end
	// Registers the routing so the analog side sees glitch-free levels.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Reset leaves every input analog and both comparators off.
			route_reg <= '0;
		end else begin
			route_reg <= route_next;
		end
	end
	assign route = route_reg;
	assign comparator_mode_field = mode_reg[2:0];
	assign cis_sel = mode_reg[3];
	assign prdata = rdata_reg;
	assign pready = (acc_reg == ACC_DONE);
	// The error register is only ever set by a setup cycle, so it stands with pready.
	assign pslverr = err_reg;
	assign cmp_irq = cmp_irq_reg;
	assign wake_req = wake_reg;
	assign irq = irq_reg;
	// Checks.
	// A mismatch must show in the change flag at the very next edge.
	chk_flag_on_change: assert property (
		@(posedge pclk) disable iff (!presetn)
		mismatch |=> compare_change_flag_reg)
		else $error("Change did not set flag.");
	// The flag is set even while the global enable is clear.
	chk_flag_no_enable: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mismatch && !global_irq_enable_reg) |=> compare_change_flag_reg)
		else $error("Flag not set with enables clear.");
	// The core request may only stand behind all three enables.
	chk_irq_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		cmp_irq |-> $past(compare_change_irq_enable_next && peripheral_irq_enable_next
		&& global_irq_enable_next))
		else $error("Interrupt without all enables.");
	// A control read returns both outputs as they stood in the setup cycle.
	chk_ctrl_bits: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ctrl_access && !pwrite) |=> prdata[7:6] == $past({live2, live1}))
		else $error("Output bits wrong in read.");
	// The reference reaches the first positive input in the internal mode only.
	chk_intref_route: assert property (
		@(posedge pclk) disable iff (!presetn)
		route.ref_to_pos1 == (comparator_mode_field == `MODE_INTREF))
		else $error("Reference routing wrong.");
	// Software writes land in the flag when no change competes.
	chk_flag_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup && pwrite && paddr == `OFF_FLAG && !mismatch)
		|=> compare_change_flag_reg == $past(pwdata[6]))
		else $error("Flag write lost.");
	// With the outputs steady, an access leaves no mismatch behind.
	chk_access_ends: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ctrl_access && $stable({live2, live1})) ##1 $stable({live2, live1}) |-> !mismatch)
		else $error("Access did not end mismatch.");
	// The off mode must power both comparators down.
	chk_off_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		(comparator_mode_field == `MODE_OFF) |-> !route.powered)
		else $error("Off mode left comparators powered.");
	// Every setup cycle is answered in the next cycle.
	chk_pready_one: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup |=> pready)
		else $error("No answer after setup.");
	// Main scenarios: change to request, control access then flag write, wake, software set.
	cov_change: cover property (@(posedge pclk) disable iff (!presetn) mismatch ##1 cmp_irq);
	cov_clear: cover property (@(posedge pclk) disable iff (!presetn)
		ctrl_access ##[1:4] (setup && pwrite && paddr == `OFF_FLAG));
	cov_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_req);
	cov_soft_set: cover property (@(posedge pclk) disable iff (!presetn)
		setup && pwrite && paddr == `OFF_FLAG && pwdata[6]);
endmodule
`default_nettype wire

// ==== include/cmp_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the comparator block.
// Assumes it is included by bare name after the package is compiled.
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH
`define OFF_CTRL 12'h000
`define OFF_FLAG 12'h004
`define OFF_PEN 12'h008
`define OFF_IRQC 12'h00c
`define OFF_IRQ_STAT 12'h010
`define OFF_IRQ_CLR 12'h014
`define OFF_IRQ_EN 12'h018
`define BIT_C2 7
`define BIT_C1 6
`define BIT_CHG 6
`define BIT_LOCAL_EN 6
`define BIT_PERIPH_EN 6
`define BIT_GLOBAL_EN 7
`define MODE_RESET 3'h0
`define MODE_INTREF 3'h2
`define MODE_OFF 3'h7
`define CTRL_RESET 8'h00
`define SYNC_STAGES 2
`endif

// ==== include/cmp_pkg.sv ====
// Types shared by the comparator block files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cmp_pkg;
	// Analog routing selections: the reference switch of each positive input, and power for both comparators.
	typedef struct packed {
		logic ref_to_pos1;
		logic ref_to_pos2;
		logic powered;
	} route_s;
	// Interrupt sticky bits.
	typedef struct packed {
		logic wake;
		logic change;
	} evt_s;
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_DONE
	} acc_e;
endpackage
`default_nettype wire

// ==== test/cmp_analog_model.sv ====
// Behavioural model of the analog comparators that sit behind the block's route outputs.
// Assumes the bench supplies the input voltages as unsigned codes and reads the raw levels.
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
	input wire cmp_pkg::route_s route, // Routing from the block.
	input wire logic [7:0] vp1, // First positive input pin.
	input wire logic [7:0] vn1, // First negative input pin.
	input wire logic [7:0] vp2, // Second positive input pin.
	input wire logic [7:0] vn2, // Second negative input pin.
	input wire logic [7:0] vref, // Internal reference level.
	output logic raw1, // First raw comparator level.
	output logic raw2 // Second raw comparator level.
);
	import cmp_pkg::*;
	logic [7:0] pos1; // Level seen at the first positive input.
	logic [7:0] pos2; // Level seen at the second positive input.
	// Selects each positive input and compares it against its own negative pin.
	always_comb begin
		// Each comparator keeps its own pins, so references may be shared or separate.
		pos1 = route.ref_to_pos1 ? vref : vp1;
		pos2 = route.ref_to_pos2 ? vref : vp2;
		// A powered-down comparator gives a steady low level.
		raw1 = route.powered & (pos1 > vn1);
		raw2 = route.powered & (pos2 > vn2);
	end
endmodule
`default_nettype wire

// ==== test/test_dual_comparator_change_interrupt.sv ====
// Self-checking bench of the comparator block over APB with an analog model.
// Assumes the block answers each APB transfer with a registered pready.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_cfg.svh"
module test_dual_comparator_change_interrupt;
	import cmp_pkg::*;
	logic pclk = 1'b0; // Bus clock.
	logic presetn = 1'b0; // Reset, active low.
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
	logic [11:0] paddr = 12'h000; // APB address.
	logic [31:0] pwdata = 32'h00000000; // APB write data.
	logic [31:0] prdata; // APB read data.
	logic pready, pslverr; // APB answer.
	logic cmp1_raw, cmp2_raw; // Raw comparator levels.
	logic sleeping = 1'b0; // Core sleep level.
	route_s route; // Analog routing.
	logic [2:0] comparator_mode_field; // Mode field.
	logic cis_sel, cmp_irq, wake_req, irq; // Status outputs.
	logic [7:0] vp1 = 8'h10, vn1 = 8'h80, vp2 = 8'h10, vn2 = 8'hf0, vref = 8'hc0; // Voltages.
	logic [31:0] rdat; // Data of the last transfer.
	logic rerr; // Error of the last transfer.
	logic [2:0] md [3] = '{3'h3, 3'h2, 3'h7}; // Modes to try.
	logic [2:0] rt [3] = '{3'h1, 3'h7, 3'h0}; // Routing expected per mode.
	int mismatches = 0;
	int checked = 0;
	cmp_top i_cmp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .sleeping(sleeping),
		.route(route), .comparator_mode_field(comparator_mode_field), .cis_sel(cis_sel),
		.cmp_irq(cmp_irq), .wake_req(wake_req), .irq(irq));
	cmp_analog_model i_cmp_analog_model (.route(route), .vp1(vp1), .vn1(vn1), .vp2(vp2),
		.vn2(vn2), .vref(vref), .raw1(cmp1_raw), .raw2(cmp2_raw));
	// Free-running 100 MHz clock.
	always #5 pclk = ~pclk;
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Compares one value and reports a difference.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; the request is held until pready is sampled high at a rising edge,
	// the answer is taken at that edge, and only then is the request released.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) begin
			mismatches++;
			$display("wrong value pready expected 1 seen %b", pready);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reads a register and compares the word.
	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(what, exp, rdat);
	endtask
	// Lets the two synchroniser stages and the flag register settle.
	task automatic settle();
		repeat (4) @(posedge pclk);
	endtask
	// Main sequence of tests.
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd("control", `OFF_CTRL, 32'h00000000);
		chk("route", 32'h0, {29'h0, route});
		chk("cis_sel", 32'h0, {31'h0, cis_sel});
		apb(1'b1, `OFF_CTRL, 32'h00000008);
		chk("cis_sel", 32'h1, {31'h0, cis_sel});
		rd("control", `OFF_CTRL, 32'h00000008);
		$display("Test reset state done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `OFF_CTRL, {29'h0, md[i]});
			chk("route", {29'h0, rt[i]}, {29'h0, route});
			chk("mode field", {29'h0, md[i]}, {29'h0, comparator_mode_field});
		end
		chk("cis_sel", 32'h0, {31'h0, cis_sel});
		$display("Test mode routing done");
		apb(1'b1, `OFF_CTRL, 32'h00000002);
		settle();
		rd("control", `OFF_CTRL, 32'h00000042);
		apb(1'b1, `OFF_FLAG, 32'h00000000);
		rd("flag", `OFF_FLAG, 32'h00000000);
		vn2 <= 8'h80;
		settle();
		rd("flag", `OFF_FLAG, 32'h00000040);
		chk("cmp_irq", 32'h0, {31'h0, cmp_irq});
		apb(1'b1, `OFF_FLAG, 32'h00000000);
		rd("flag", `OFF_FLAG, 32'h00000040);
		rd("control", `OFF_CTRL, 32'h000000c2);
		apb(1'b1, `OFF_FLAG, 32'h00000000);
		rd("flag", `OFF_FLAG, 32'h00000000);
		$display("Test change flag done");
		apb(1'b1, `OFF_FLAG, 32'h00000040);
		rd("flag", `OFF_FLAG, 32'h00000040);
		apb(1'b1, `OFF_PEN, 32'h00000040);
		apb(1'b1, `OFF_IRQC, 32'h00000040);
		repeat (2) @(posedge pclk);
		chk("cmp_irq", 32'h0, {31'h0, cmp_irq});
		apb(1'b1, `OFF_IRQC, 32'h000000c0);
		repeat (2) @(posedge pclk);
		chk("cmp_irq", 32'h1, {31'h0, cmp_irq});
		sleeping <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("wake_req", 32'h1, {31'h0, wake_req});
		rd("control", `OFF_CTRL, 32'h000000c2);
		sleeping <= 1'b0;
		apb(1'b1, `OFF_IRQC, 32'h00000040);
		repeat (2) @(posedge pclk);
		chk("cmp_irq", 32'h0, {31'h0, cmp_irq});
		$display("Test enables done");
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b0, `OFF_IRQ_STAT, 32'h00000000);
		chk("status", 32'h1, rdat & 32'h1);
		apb(1'b1, `OFF_IRQ_EN, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, `OFF_FLAG, 32'h00000000);
		apb(1'b1, `OFF_IRQ_CLR, 32'h00000003);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b0, `OFF_IRQ_STAT, 32'h00000000);
		chk("status", 32'h0, rdat & 32'h1);
		apb(1'b0, 12'h100, 32'h00000000);
		chk("pslverr", 32'h1, {31'h0, rerr});
		chk("unmapped data", 32'h0, rdat);
		$display("Test interrupt line done");
		conclude();
	end
	// Cuts a hang short after far more time than the tests need.
	initial begin
		#100000;
		mismatches++;
		$display("wrong value watchdog expected done seen timeout");
		conclude();
	end
endmodule
`default_nettype wire
